// ==== rtl/fftf_top.sv ====
// Frame transform block: APB control, frame buffers, radix-2 engine, result FIFO
//
// Function
// [R01] Transform length is a build-time power of two between 8 and 65536; the code fixes it at 8 (FFTF_LEN).
// [R02] Scaled mode shifts every stage, schedule set by transform length.
// [R03] Unscaled mode keeps all growth; output widened by log2 length bits.
// [R04] Output order is natural or bit-reversed, as configured.
// [R05] Area mode with slow input selects the burst architecture.
// [R06] All other settings use the pipelined streaming architecture.
// [R07] Unscaled mode takes signed input with any binary point.
// [R08] Scaled fixed input must be normalised, one sign bit, rest fraction.
// [R09] Floating input may run scaled or unscaled.
// [R10] Scaled schedule is conservative so no stage can overflow.
// [R11] Upstream always drives a defined frame-start level.
// [R12] A one-cycle frame-start pulse marks each frame's first input sample.
// [R13] Each frame is exactly one transform length of samples.
// [R14] Output frame-start is high only with each frame's first result.
// [R15] Frame-start ports act only in the streaming architecture.
// [R16] Frame-start ports act only for fixed-point input.
// [R17] The first sample after start-up may be lost; upstream must not rely.
// [R18] Result index counts 0..N-1, natural or bit-reversed sequence.
// [R19] Streaming takes one sample per cycle and yields one result per cycle.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------
module fftf_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } fftf_fifo_st_t;

    fftf_fifo_st_t q;
    fftf_fifo_st_t d;
    logic push;
    logic pop;

    assign inReady = (q.cnt != CW'(DEPTH));
    assign outValid = (q.cnt != '0);
    assign outData = q.mem[q.rp];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = inData;
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : AW'(q.wp + 1'b1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : AW'(q.rp + 1'b1);
        end
        case ({push, pop})
            2'b10: d.cnt = CW'(q.cnt + 1'b1);
            2'b01: d.cnt = CW'(q.cnt - 1'b1);
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module fftf_top
    import fftf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [FFTF_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample input stream
    input wire logic sampleValid,
    input wire fftf_in_t sampleIn,
    input wire logic frameStartIn,
    output logic sampleReady,
    // Result output stream
    output logic resultValid,
    output logic signed [FFTF_OUT_W-1:0] real_result,
    output logic signed [FFTF_OUT_W-1:0] imag_result,
    output logic [FFTF_LOG_LEN-1:0] output_sample_index,
    output logic frameStartOut,
    input wire logic resultReady
);
    typedef struct packed {
        fftf_ctrl_t ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        fftf_in_t [FFTF_LEN-1:0] inBuf;
        logic [2:0] inCnt;
        logic inFull;
        logic inReady;
        fftf_cplx_t [FFTF_LEN-1:0] work;
        fftf_work_t wk;
        logic [1:0] stage;
        fftf_cplx_t [FFTF_LEN-1:0] outBuf;
        logic [2:0] outCnt;
        logic outBusy;
        logic [7:0] frameCnt;
    } fftf_state_t;

    fftf_state_t q;
    fftf_state_t d;

    logic streaming;
    logic portsOn;
    logic fifoInReady;
    fftf_res_t pushRes;
    fftf_res_t popRes;
    logic [2:0] topIdx [4];
    logic [2:0] botIdx [4];
    fftf_cplx_t bflyTop [4];
    fftf_cplx_t bflyBot [4];

    // Burst only when both area and slow input are chosen
    assign streaming = ~(q.ctrl.areaOpt & q.ctrl.slowInput); // [R05] [R06]
    assign portsOn = streaming & ~q.ctrl.floatIn; // [R15] [R16]

    // ------------------------------------------------------------
    // Radix-2 butterflies, one stage per cycle
    // ------------------------------------------------------------
    genvar gj;
    generate
        for (gj = 0; gj < 4; gj++) begin : g_bfly
            logic [1:0] jv;
            logic [2:0] span;
            logic [1:0] twk;
            fftf_cplx_t a;
            fftf_cplx_t b;
            logic signed [35:0] pRe;
            logic signed [35:0] pIm;
            logic signed [FFTF_OUT_W:0] sTopRe;
            logic signed [FFTF_OUT_W:0] sTopIm;
            logic signed [FFTF_OUT_W:0] sBotRe;
            logic signed [FFTF_OUT_W:0] sBotIm;
            logic signed [FFTF_OUT_W-1:0] tRe;
            logic signed [FFTF_OUT_W-1:0] tIm;

            assign jv = 2'(gj);
            assign span = 3'(3'h1 << q.stage);
            assign topIdx[gj] = 3'((({1'b0, jv} >> q.stage) << (q.stage + 2'h1))
                | ({1'b0, jv} & 3'(span - 3'h1)));
            assign botIdx[gj] = 3'(topIdx[gj] + span);
            assign twk = 2'(({1'b0, jv} & 3'(span - 3'h1)) << (FFTF_LAST_STAGE - q.stage));
            assign a = q.work[topIdx[gj]];
            assign b = q.work[botIdx[gj]];
            assign pRe = 36'(b.re * fftfTwRe(twk)) - 36'(b.im * fftfTwIm(twk));
            assign pIm = 36'(b.re * fftfTwIm(twk)) + 36'(b.im * fftfTwRe(twk));
            assign tRe = pRe[FFTF_TW_FRAC +: FFTF_OUT_W];
            assign tIm = pIm[FFTF_TW_FRAC +: FFTF_OUT_W];
            assign sTopRe = a.re + tRe;
            assign sTopIm = a.im + tIm;
            assign sBotRe = a.re - tRe;
            assign sBotIm = a.im - tIm;
            // Halving per stage bounds |a + b*w| to the input range
            assign bflyTop[gj].re = q.ctrl.scaleEn ? sTopRe[FFTF_OUT_W:1]
                : sTopRe[FFTF_OUT_W-1:0]; // [R02] [R03] [R10]
            assign bflyTop[gj].im = q.ctrl.scaleEn ? sTopIm[FFTF_OUT_W:1]
                : sTopIm[FFTF_OUT_W-1:0]; // [R02] [R03] [R10]
            assign bflyBot[gj].re = q.ctrl.scaleEn ? sBotRe[FFTF_OUT_W:1]
                : sBotRe[FFTF_OUT_W-1:0]; // [R02] [R03] [R10]
            assign bflyBot[gj].im = q.ctrl.scaleEn ? sBotIm[FFTF_OUT_W:1]
                : sBotIm[FFTF_OUT_W-1:0]; // [R02] [R03] [R10]
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] wrIdx;
        logic [2:0] rdIdx;
        logic lastOut;
        wrIdx = '0;
        rdIdx = '0;
        lastOut = 1'b0;
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;

        // APB: one wait state, then pready with registered data
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            case (paddr)
                FFTF_CTRL_OFS: begin
                    if (pwrite) begin
                        d.ctrl = pwdata[4:0]; // [R09]
                    end else begin
                        d.prdata = {27'h0, q.ctrl};
                    end
                end
                FFTF_STATUS_OFS: begin
                    if (!pwrite) begin
                        d.prdata = '0;
                        d.prdata[FFTF_STAT_STREAM_BIT] = streaming;
                        d.prdata[FFTF_STAT_PORTS_BIT] = portsOn;
                        d.prdata[FFTF_STAT_BUSY_BIT] = (q.inCnt != '0) | q.inFull
                            | (q.wk != WK_IDLE) | q.outBusy;
                        d.prdata[FFTF_STAT_FRAMES_LSB +: 8] = q.frameCnt;
                    end
                end
                default: begin
                    d.pslverr = 1'b1;
                    d.prdata = '0;
                end
            endcase
        end

        // Result drain into the FIFO
        rdIdx = q.ctrl.naturalOrder ? q.outCnt : fftfBitRev(q.outCnt); // [R04] [R18]
        pushRes.data = q.outBuf[rdIdx];
        pushRes.index = rdIdx; // [R18]
        pushRes.frameStart = portsOn & (q.outCnt == '0); // [R14]
        if (q.outBusy && fifoInReady) begin
            d.outCnt = 3'(q.outCnt + 3'h1);
            if (q.outCnt == FFTF_LAST_IDX) begin
                lastOut = 1'b1;
                d.outBusy = 1'b0;
                d.frameCnt = 8'(q.frameCnt + 8'h1);
            end
        end

        // Transform engine
        case (q.wk)
            WK_IDLE: begin
                if (q.inFull) begin
                    for (int i = 0; i < FFTF_LEN; i++) begin // [R01]
                        // Sign extension only; binary point is the caller's
                        d.work[i].re = FFTF_OUT_W'(q.inBuf[i].re); // [R07] [R08]
                        d.work[i].im = FFTF_OUT_W'(q.inBuf[i].im); // [R07] [R08]
                    end
                    d.inFull = 1'b0;
                    d.stage = '0;
                    d.wk = WK_COMPUTE;
                end
            end
            WK_COMPUTE: begin
                for (int j = 0; j < 4; j++) begin
                    d.work[topIdx[j]] = bflyTop[j];
                    d.work[botIdx[j]] = bflyBot[j];
                end
                d.stage = 2'(q.stage + 2'h1);
                if (q.stage == FFTF_LAST_STAGE) begin
                    d.wk = WK_HOLD;
                end
            end
            WK_HOLD: begin
                // Handover on the last push keeps the output gapless
                if (!q.outBusy || lastOut) begin
                    d.outBuf = q.work;
                    d.outCnt = '0;
                    d.outBusy = 1'b1; // [R19]
                    d.wk = WK_IDLE;
                end
            end
            default: begin
                d.wk = WK_IDLE;
            end
        endcase

        // Frame capture; every accepted sample is written, the first one included
        if (sampleValid && q.inReady) begin // [R17]
            // Frame start restarts the count, dropping a partial frame
            wrIdx = (frameStartIn && portsOn) ? 3'h0 : q.inCnt; // [R11] [R12]
            d.inBuf[fftfBitRev(wrIdx)] = sampleIn;
            d.inCnt = 3'(wrIdx + 3'h1); // [R13]
            if (wrIdx == FFTF_LAST_IDX) begin
                d.inFull = 1'b1; // [R13]
            end
        end

        // Streaming overlaps load with compute; burst runs one frame at a time
        if (streaming) begin
            d.inReady = !d.inFull || (d.wk == WK_IDLE); // [R06] [R19]
        end else begin
            d.inReady = !d.inFull && (d.wk == WK_IDLE) && !d.outBusy; // [R05]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= FFTF_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Result buffering and ports
    // ------------------------------------------------------------
    fftf_fifo #(
        .WIDTH($bits(fftf_res_t)),
        .DEPTH(FFTF_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inValid(q.outBusy),
        .inData(pushRes),
        .inReady(fifoInReady),
        .outValid(resultValid),
        .outData(popRes),
        .outReady(resultReady)
    );

    assign real_result = popRes.data.re;
    assign imag_result = popRes.data.im;
    assign output_sample_index = popRes.index;
    assign frameStartOut = popRes.frameStart & resultValid; // [R14]
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign sampleReady = q.inReady;
endmodule

// ==== rtl/fftf_pkg.sv ====
// Shared constants, types and helpers of the frame transform block
package fftf_pkg;

    // ------------------------------------------------------------
    // Transform geometry
    // ------------------------------------------------------------
    localparam int FFTF_LOG_LEN = 3;
    localparam int FFTF_LEN = 8;
    localparam int FFTF_IN_W = 16;
    localparam int FFTF_OUT_W = 19;
    localparam int FFTF_TW_FRAC = 15;
    localparam int FFTF_FIFO_DEPTH = 8;
    localparam logic [2:0] FFTF_LAST_IDX = 3'h7;
    localparam logic [1:0] FFTF_LAST_STAGE = 2'h2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int FFTF_ADDR_W = 8;
    localparam logic [7:0] FFTF_CTRL_OFS = 8'h00;
    localparam logic [7:0] FFTF_STATUS_OFS = 8'h04;
    localparam int FFTF_CTRL_SCALE_BIT = 0;
    localparam int FFTF_CTRL_NATURAL_BIT = 1;
    localparam int FFTF_CTRL_AREA_BIT = 2;
    localparam int FFTF_CTRL_SLOW_BIT = 3;
    localparam int FFTF_CTRL_FLOAT_BIT = 4;
    localparam logic [4:0] FFTF_CTRL_RST = 5'h03;
    localparam int FFTF_STAT_STREAM_BIT = 0;
    localparam int FFTF_STAT_PORTS_BIT = 1;
    localparam int FFTF_STAT_BUSY_BIT = 2;
    localparam int FFTF_STAT_FRAMES_LSB = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic floatIn;
        logic slowInput;
        logic areaOpt;
        logic naturalOrder;
        logic scaleEn;
    } fftf_ctrl_t;

    typedef struct packed {
        logic signed [FFTF_IN_W-1:0] re;
        logic signed [FFTF_IN_W-1:0] im;
    } fftf_in_t;

    typedef struct packed {
        logic signed [FFTF_OUT_W-1:0] re;
        logic signed [FFTF_OUT_W-1:0] im;
    } fftf_cplx_t;

    typedef struct packed {
        fftf_cplx_t data;
        logic [FFTF_LOG_LEN-1:0] index;
        logic frameStart;
    } fftf_res_t;

    typedef enum logic [1:0] {WK_IDLE, WK_COMPUTE, WK_HOLD} fftf_work_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] fftfBitRev(input logic [2:0] i);
        return {i[0], i[1], i[2]};
    endfunction

    // Twiddle factors W8^k, Q1.15 in 17 bits so that 1.0 is exact
    function automatic logic signed [16:0] fftfTwRe(input logic [1:0] k);
        case (k)
            2'h0: return 17'h08000;
            2'h1: return 17'h05A82;
            2'h2: return 17'h00000;
            default: return 17'h1A57E;
        endcase
    endfunction

    function automatic logic signed [16:0] fftfTwIm(input logic [1:0] k);
        case (k)
            2'h0: return 17'h00000;
            2'h1: return 17'h1A57E;
            2'h2: return 17'h18000;
            default: return 17'h1A57E;
        endcase
    endfunction

endpackage

// ==== tb/fftf_top_chk.sv ====
// Port assertions for the frame transform block
`timescale 1ns/1ps

module fftf_top_chk
    import fftf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Result stream
    input wire logic resultValid,
    input wire logic signed [FFTF_OUT_W-1:0] real_result,
    input wire logic signed [FFTF_OUT_W-1:0] imag_result,
    input wire logic [FFTF_LOG_LEN-1:0] output_sample_index,
    input wire logic frameStartOut,
    input wire logic resultReady
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic pop;
    logic [2:0] idx;
    logic [2:0] revInc;
    logic [2:0] nextRev;
    assign pop = resultValid && resultReady;
    assign idx = output_sample_index;
    // Successor of idx when counting in bit-reversed order
    assign revInc = {idx[0], idx[1], idx[2]} + 3'h1;
    assign nextRev = {revInc[0], revInc[1], revInc[2]};

    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no pready one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    a_error_pairs: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_error_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read returned data");
    a_start_first: assert property (resultValid && frameStartOut |-> idx == 3'h0)
        else $error("frame start on later result");
    a_result_hold: assert property (resultValid && !resultReady |=> resultValid
        && $stable(real_result) && $stable(imag_result) && $stable(idx))
        else $error("result changed while stalled");
    a_frame_wrap: assert property (pop && idx == 3'h7 |=> !resultValid || idx == 3'h0)
        else $error("frame not closed at index seven");
    a_index_step: assert property (pop && idx != 3'h7 |=> !resultValid
        || idx == $past(idx) + 3'h1 || idx == $past(nextRev))
        else $error("index out of sequence");
endmodule

bind fftf_top fftf_top_chk i_fftf_top_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .resultValid, .real_result, .imag_result,
    .output_sample_index, .frameStartOut, .resultReady);

// ==== tb/fftf_partner.sv ====
// Stream source and result sink facing the frame transform block
`timescale 1ns/1ps

module fftf_partner
    import fftf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic sendGo,
    input wire logic [3:0] sendN,
    input wire logic sendFs,
    input wire logic [15:0] sendVal,
    input wire logic stall,
    output logic sendBusy,
    // Sample stream
    output logic sampleValid,
    output fftf_in_t sampleIn,
    output logic frameStartIn,
    input wire logic sampleReady,
    // Result stream
    input wire logic resultValid,
    input wire logic signed [FFTF_OUT_W-1:0] real_result,
    input wire logic signed [FFTF_OUT_W-1:0] imag_result,
    input wire logic [FFTF_LOG_LEN-1:0] output_sample_index,
    input wire logic frameStartOut,
    output logic resultReady
);
    logic [3:0] left;
    logic [3:0] pos;
    logic [5:0] nGot;
    fftf_res_t got [64];

    assign sendBusy = sampleValid || left != 4'h0;
    assign resultReady = !stall;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 4'h0;
            pos <= 4'h0;
            sampleValid <= 1'b0;
            frameStartIn <= 1'b0;
            sampleIn <= '0;
        end else if (sendGo) begin
            left <= sendN;
            pos <= 4'h0;
        end else if (!sampleValid || sampleReady) begin
            if (left != 4'h0) begin
                sampleValid <= 1'b1;
                sampleIn.re <= sendVal;
                sampleIn.im <= 16'h0000;
                frameStartIn <= sendFs && pos == 4'h0;
                pos <= pos + 4'h1;
                left <= left - 4'h1;
            end else begin
                sampleValid <= 1'b0;
                frameStartIn <= 1'b0;
                // Released data keeps moving so stale words never look valid
                sampleIn <= ~sampleIn;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nGot <= 6'h00;
        end else if (resultValid && resultReady) begin
            got[nGot] <= {real_result, imag_result, output_sample_index, frameStartOut};
            nGot <= nGot + 6'h01;
        end
    end
endmodule

// ==== tb/fftf_top_test.sv ====
// Self-checking bench for the frame transform block
`timescale 1ns/1ps

module fftf_top_test
    import fftf_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, err, sampleValid, frameStartIn, sampleReady, sendBusy;
    logic resultValid, frameStartOut, resultReady;
    fftf_in_t sampleIn;
    logic signed [FFTF_OUT_W-1:0] real_result, imag_result;
    logic [FFTF_LOG_LEN-1:0] output_sample_index;
    logic sendGo = 1'b0;
    logic sendFs = 1'b0;
    logic stall = 1'b0;
    logic [3:0] sendN = 4'h8;
    logic [15:0] sendVal = 16'h0000;
    int nMismatch = 0;
    int totalChecks = 0;

    always #20 ref_clk = ~ref_clk;

    fftf_top i_fftf_top (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .sampleValid, .sampleIn, .frameStartIn, .sampleReady, .resultValid,
        .real_result, .imag_result, .output_sample_index, .frameStartOut, .resultReady);
    fftf_partner i_fftf_partner (.ref_clk, .rst_n, .sendGo, .sendN, .sendFs, .sendVal, .stall,
        .sendBusy, .sampleValid, .sampleIn, .frameStartIn, .sampleReady, .resultValid,
        .real_result, .imag_result, .output_sample_index, .frameStartOut, .resultReady);

    // --------
    // Shared tasks
    // --------
    task automatic summarize();
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg, input bit hang);
        $display("mismatch at %0t: %s", $time, msg);
        nMismatch++;
        if (hang) summarize();
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
        totalChecks++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp), 1'b0);
    endtask

    task automatic chkRes(input int k, input logic [18:0] re, input logic [2:0] ix, input logic fs);
        fftf_res_t r;
        r = i_fftf_partner.got[k % 64];
        totalChecks++;
        if (r !== {re, 19'h00000, ix, fs}) fail($sformatf("result %0d is %h", k, r), 1'b0);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int c;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (pready !== 1'b1 && c < 50);
        if (c >= 50) fail("apb hang", 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic frame(input logic [3:0] n, input logic fs, input logic [15:0] v, input bit w);
        int c;
        sendN <= n;
        sendFs <= fs;
        sendVal <= v;
        sendGo <= 1'b1;
        @(posedge ref_clk);
        sendGo <= 1'b0;
        @(posedge ref_clk);
        c = 0;
        while (w && sendBusy !== 1'b0 && c < 400) begin
            @(posedge ref_clk);
            c++;
        end
        if (c >= 400) fail("send hang", 1'b1);
    endtask

    task automatic collect(input logic [5:0] b, input logic [5:0] cnt);
        int c;
        c = 0;
        while (i_fftf_partner.nGot - b != cnt && c < 400) begin
            @(posedge ref_clk);
            c++;
        end
        if (c >= 400) fail("result hang", 1'b1);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic scnRegs();
        apb(1'b0, FFTF_CTRL_OFS, 32'h00000000);
        chkVal(rdv, 32'h00000003, "ctrl reset");
        apb(1'b1, FFTF_STATUS_OFS, 32'h00000000);
        apb(1'b0, FFTF_STATUS_OFS, 32'h00000000);
        chkVal(rdv & 32'h00000007, 32'h00000003, "status");
        apb(1'b1, FFTF_CTRL_OFS, 32'hFFFFFFE3);
        apb(1'b0, FFTF_CTRL_OFS, 32'h00000000);
        chkVal(rdv, 32'h00000003, "ctrl mask");
        apb(1'b0, 8'h08, 32'h00000000);
        chkVal(rdv, 32'h00000000, "unmapped data");
        chkVal({31'h0, err}, 32'h00000001, "unmapped error");
    endtask

    task automatic scnFrame(input logic [31:0] ctrl, input logic [18:0] dc, input bit rev);
        logic [5:0] b;
        apb(1'b1, FFTF_CTRL_OFS, ctrl);
        b = i_fftf_partner.nGot;
        frame(4'h8, 1'b1, ctrl[0] ? 16'h4000 : 16'h1000, 1'b1);
        collect(b, 6'h08);
        for (int k = 0; k < 8; k++) begin
            chkRes(b + k, k == 0 ? dc : 19'h00000, rev ? {k[0], k[1], k[2]} : 3'(k), k == 0);
        end
    endtask

    task automatic scnPortsOff(input logic [31:0] ctrl, input logic [31:0] stat);
        logic [5:0] b;
        apb(1'b1, FFTF_CTRL_OFS, ctrl);
        apb(1'b0, FFTF_STATUS_OFS, 32'h00000000);
        chkVal(rdv & 32'h00000003, stat, "arch status");
        b = i_fftf_partner.nGot;
        frame(4'h8, 1'b1, 16'h4000, 1'b1);
        collect(b, 6'h08);
        for (int k = 0; k < 8; k++) begin
            chkRes(b + k, k == 0 ? 19'h04000 : 19'h00000, {k[0], k[1], k[2]}, 1'b0);
        end
    endtask

    task automatic scnFill();
        logic [5:0] b;
        logic seen;
        int f;
        int c;
        apb(1'b1, FFTF_CTRL_OFS, 32'h00000003);
        b = i_fftf_partner.nGot;
        stall <= 1'b1;
        seen = 1'b0;
        f = 0;
        // FIFO, output, engine and input buffers absorb four frames; the fifth waits
        while (!seen && f < 5) begin
            frame(4'h8, 1'b1, 16'h4000, 1'b0);
            f++;
            c = 0;
            while (sendBusy === 1'b1 && c < 60) begin
                @(posedge ref_clk);
                c++;
                seen |= sampleValid && !sampleReady;
            end
        end
        chkVal({31'h0, seen}, 32'h00000001, "input never refused");
        stall <= 1'b0;
        collect(b, 6'(f * 8));
        for (int k = 0; k < f * 8; k++) begin
            chkRes(b + k, k % 8 == 0 ? 19'h04000 : 19'h00000, 3'(k % 8), k % 8 == 0);
        end
        chkVal({31'h0, resultValid}, 32'h00000000, "fifo not empty");
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        scnRegs();
        frame(4'h3, 1'b0, 16'h7FFF, 1'b1);
        scnFrame(32'h00000003, 19'h04000, 1'b0);
        scnFrame(32'h00000000, 19'h08000, 1'b1);
        scnPortsOff(32'h0000000D, 32'h00000000);
        scnPortsOff(32'h00000011, 32'h00000001);
        scnFill();
        summarize();
    end
endmodule
